// ===== pkg/quad_dac_pkg.sv
`default_nettype none
package quad_dac_pkg;
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 14;
  localparam int CHANNELS = 4;
  localparam int CHAN_BITS = 2;
  localparam int CHAN_LSB = 14;
  localparam int CHAIN_DELAY = 17;
  localparam logic [13:0] ZERO_CODE = 14'h0000;
  localparam logic [13:0] HALF_CODE = 14'h2000;
  localparam logic [1:0] POR_HOLD = 2'h3;
  localparam logic [1:0] POR_START = 2'h0;
  localparam logic [1:0] POR_STEP = 2'h1;
  // synchroniser idle levels, order {levelSelect, loadAllStrobeN, presetN, chipSelectN}
  localparam logic [3:0] PIN_IDLE = 4'h7;
  localparam int PIN_CS = 0;
  localparam int PIN_PRESET = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_LEVEL = 3;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef logic [DATA_BITS-1:0] code_t;
  typedef logic [WORD_BITS-1:0] word_t;
  typedef logic [CHAN_BITS-1:0] chan_t;
endpackage : quad_dac_pkg
`default_nettype wire

// ===== pkg/shift_if.sv
`default_nettype none
interface shift_if;
  quad_dac_pkg::word_t word;
  logic chain;
  modport link (output word, output chain);
  modport core (input word, input chain);
endinterface : shift_if
`default_nettype wire

// ===== src/serial_shifter.sv
`default_nettype none
module serial_shifter
(
  input wire logic sclk,
  input wire logic arst_n,
  input wire logic chipSelectN,
  input wire logic shiftIn,
  shift_if.link bus
);
  import quad_dac_pkg::*;

  word_t shiftQ;
  word_t shiftD;
  logic chainQ;
  logic chainD;

  // msb first: older bits walk toward the top and fall off, so only the last 16 remain
  assign shiftD = chipSelectN ? shiftQ : {shiftQ[WORD_BITS-2:0], shiftIn};
  // one stage past the word gives the 17-edge echo
  assign chainD = chipSelectN ? chainQ : shiftQ[WORD_BITS-1];

  // sclk may stop between frames, so this domain resets straight from the pin;
  // the host must not clock while reset is low
  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shiftQ <= WORD_RESET;
      chainQ <= 1'b0;
    end
    else
    begin
      shiftQ <= shiftD;
      chainQ <= chainD;
    end
  end

  assign bus.word = shiftQ;
  assign bus.chain = chainQ;

  shift_in_a: assert property (@(posedge sclk) disable iff (!arst_n)
    !chipSelectN |=> shiftQ[0] == $past(shiftIn) && shiftQ[WORD_BITS-1:1] ==
      $past(shiftQ[WORD_BITS-2:0]))
    else $error("shift register did not take the serial bit");
  shift_hold_a: assert property (@(posedge sclk) disable iff (!arst_n)
    chipSelectN |=> $stable(shiftQ) && $stable(chainQ))
    else $error("shift register moved while deselected");
  chain_echo_a: assert property (@(posedge sclk) disable iff (!arst_n)
    (!chipSelectN)[*8] ##1 (!chipSelectN)[*8] ##1 !chipSelectN
      |=> chainQ == $past(shiftIn, 17))
    else $error("chain output is not the input 17 edges late");
endmodule : serial_shifter
`default_nettype wire

// ===== src/quad_dac_serial_load_logic.sv
// Functional notes
// - while preset is low every input and converter register is forced to zero or 2000h by level select.
// - after power-up the same level-selected preset value is loaded into all registers.
// - serial clock edges do not shift while chip select is high.
// - the rising edge of chip select copies the shift register into the addressed input register.
// - the load-all strobe works regardless of chip select or any transfer in progress.
// - each rising serial clock edge while selected shifts the serial input bit in.
// - each serial bit appears on the chain output on the 16th serial clock pulse after the one that took it.
// - while the load-all strobe is low all input registers are copied into the converter registers.
// - words are 16 bits sent most significant bit first.
// - at chip select rise only the last 16 bits shifted in are used.
// - the two channel-select bits of the word pick the target input register.
// - after a preset the converter registers keep that value until a load replaces it.
`default_nettype none
module quad_dac_serial_load_logic
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic shiftIn,
  input wire logic presetN,
  input wire logic levelSelect,
  input wire logic loadAllStrobeN,
  output logic chainOut,
  output quad_dac_pkg::code_t inputCode [quad_dac_pkg::CHANNELS],
  output quad_dac_pkg::code_t dacCode [quad_dac_pkg::CHANNELS]
);
  import quad_dac_pkg::*;

  logic [1:0] rstSyncQ;
  logic rstN;
  logic [3:0] pinRaw;
  logic [3:0] pinMetaQ;
  logic [3:0] pinSyncQ;
  logic csPrevQ;
  logic csSync;
  logic presetSync;
  logic loadSync;
  logic levelSync;
  logic [1:0] porQ;
  logic [1:0] porD;
  logic powerOn;
  logic csRise;
  logic presetActive;
  logic loadActive;
  code_t presetCode;
  word_t word;
  logic channelSelectHi;
  logic channelSelectLo;
  chan_t channel;
  code_t wordData;
  logic [CHANNELS-1:0] writeHit;
  code_t inputQ [CHANNELS];
  code_t dacQ [CHANNELS];

  shift_if bus ();

  serial_shifter u_shifter
  (
    .sclk(sclk),
    .arst_n(arst_n),
    .chipSelectN(chipSelectN),
    .shiftIn(shiftIn),
    .bus(bus)
  );

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSyncQ <= 2'h0;
    end
    else
    begin
      rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
  end
  assign rstN = rstSyncQ[1];

  // all four control pins are asynchronous here; only the second stage is read
  assign pinRaw = {levelSelect, loadAllStrobeN, presetN, chipSelectN};

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      pinMetaQ <= PIN_IDLE;
      pinSyncQ <= PIN_IDLE;
      csPrevQ <= 1'b1;
    end
    else
    begin
      pinMetaQ <= pinRaw;
      pinSyncQ <= pinMetaQ;
      csPrevQ <= pinSyncQ[PIN_CS];
    end
  end

  // only the second stage is tapped; the first may still be settling
  assign csSync = pinSyncQ[PIN_CS];
  assign presetSync = pinSyncQ[PIN_PRESET];
  assign loadSync = pinSyncQ[PIN_LOAD];
  assign levelSync = pinSyncQ[PIN_LEVEL];

  // the level pin cannot be sampled under reset, so a short window after release
  // applies the preset once the synchroniser holds a real level
  assign powerOn = porQ != POR_HOLD;
  assign porD = powerOn ? porQ + POR_STEP : porQ;

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      porQ <= POR_START;
    end
    else
    begin
      porQ <= porD;
    end
  end

  // the window opens once per reset; a wrap of the counter would wipe loaded codes
  por_once_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    !powerOn |=> !powerOn)
    else $error("power-on window opened again without a reset");
  por_half_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    $fell(powerOn) && $past(levelSync) |-> inputQ[0] == HALF_CODE && dacQ[0] == HALF_CODE)
    else $error("power-on did not leave half-scale");
  por_zero_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    $fell(powerOn) && !$past(levelSync) |-> inputQ[0] == ZERO_CODE && dacQ[0] == ZERO_CODE)
    else $error("power-on did not leave zero");

  assign csRise = csSync & ~csPrevQ;
  // preset outranks a write or the strobe landing in the same cycle
  assign presetActive = powerOn | ~presetSync;
  assign presetCode = levelSync ? HALF_CODE : ZERO_CODE;
  // chip select plays no part in the strobe path
  assign loadActive = ~loadSync;

  // the word is still while chip select is high, so it is safe to take after the
  // synchronised rise; the host must keep select high for about four clk_sys cycles
  assign word = bus.word;
  assign channelSelectHi = word[CHAN_LSB+1];
  assign channelSelectLo = word[CHAN_LSB];
  assign channel = {channelSelectHi, channelSelectLo};
  assign wordData = word[DATA_BITS-1:0];

  // the word is read across domains with no copy of its own;
  // it must not move in the cycle that takes it
  word_still_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    csRise |-> $stable(word))
    else $error("shift word moved while it was taken");

  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++)
    begin : g_chan
      code_t inputD;
      code_t dacD;

      assign writeHit[i] = csRise & (channel == chan_t'(i));
      assign inputD = presetActive ? presetCode :
        writeHit[i] ? wordData : inputQ[i];
      assign dacD = presetActive ? presetCode :
        loadActive ? inputQ[i] : dacQ[i];

      always_ff @(posedge clk_sys or negedge rstN)
      begin
        if (!rstN)
        begin
          inputQ[i] <= ZERO_CODE;
          dacQ[i] <= ZERO_CODE;
        end
        else
        begin
          inputQ[i] <= inputD;
          dacQ[i] <= dacD;
        end
      end

      assign inputCode[i] = inputQ[i];
      assign dacCode[i] = dacQ[i];

      preset_force_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        presetActive |=> inputQ[i] == $past(presetCode) && dacQ[i] == $past(presetCode))
        else $error("preset did not force both registers");
      cs_write_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        writeHit[i] && !presetActive |=> inputQ[i] == $past(wordData))
        else $error("chip select rise did not load the addressed register");
      input_hold_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        !writeHit[i] && !presetActive |=> $stable(inputQ[i]))
        else $error("input register changed without a write to it");
      load_copy_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        loadActive && !presetActive |=> dacQ[i] == $past(inputQ[i]))
        else $error("load strobe did not copy the input register");
      dac_hold_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        !loadActive && !presetActive |=> $stable(dacQ[i]))
        else $error("converter register changed without a load");

      // preset checked against the constants rather than against presetCode
      preset_half_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        !presetSync && levelSync |=> inputQ[i] == HALF_CODE && dacQ[i] == HALF_CODE)
        else $error("preset with level high did not give half-scale");
      preset_zero_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        !presetSync && !levelSync |=> inputQ[i] == ZERO_CODE && dacQ[i] == ZERO_CODE)
        else $error("preset with level low did not give zero");
      chan_pick_a: assert property (@(posedge clk_sys) disable iff (!rstN)
        writeHit[i] |-> word[CHAN_LSB+1:CHAN_LSB] == chan_t'(i))
        else $error("write went to a channel the word did not select");
    end
  endgenerate

  assign chainOut = bus.chain;

  por_window_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    $rose(rstN) |-> powerOn[*3] ##1 !powerOn)
    else $error("power-on preset window has the wrong length");
  strobe_free_a: assert property (@(posedge clk_sys) disable iff (!rstN)
    loadActive && !presetActive && csRise |=> dacQ[0] == $past(inputQ[0]))
    else $error("chip select disturbed the load strobe");
endmodule : quad_dac_serial_load_logic
`default_nettype wire

// ===== test/serial_host.sv
`default_nettype none
module serial_host
(
  output logic sclk,
  output logic chipSelectN,
  output logic shiftIn,
  input wire logic chainOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sent[$];
  logic seen[$];
  initial
  begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    shiftIn = 1'b0;
  end
  task automatic hold(input logic v);
    chipSelectN <= v;
  endtask : hold
  // msb first, 64 ns clock runs only inside send, also when sel leaves select high
  task automatic send(input logic [31:0] w, input int n, input logic sel);
    sent.delete();
    seen.delete();
    chipSelectN = ~sel;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      shiftIn = w[i];
      #32 sclk = 1'b1;
      sent.push_back(w[i]);
      #1 seen.push_back(chainOut);
      #31 sclk = 1'b0;
    end
    // released line shows the inverse, not a stale bit
    shiftIn = ~shiftIn;
    #40 chipSelectN = 1'b1;
    #100;
  endtask : send
endmodule : serial_host
`default_nettype wire

// ===== test/quad_dac_serial_load_logic_tb.sv
`default_nettype none
module quad_dac_serial_load_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import quad_dac_pkg::*;
  logic clk_sys, arst_n, presetN, levelSelect, loadAllStrobeN;
  logic sclk, chipSelectN, shiftIn, chainOut;
  code_t inputCode [CHANNELS];
  code_t dacCode [CHANNELS];
  code_t expIn [CHANNELS];
  code_t expDac [CHANNELS];
  code_t dat [CHANNELS] = '{14'h3FFF, 14'h0001, 14'h2AAA, 14'h1555};
  int n_fail = 0;
  int comparisons = 0;
  quad_dac_serial_load_logic dut (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk),
    .chipSelectN(chipSelectN), .shiftIn(shiftIn), .presetN(presetN),
    .levelSelect(levelSelect), .loadAllStrobeN(loadAllStrobeN), .chainOut(chainOut),
    .inputCode(inputCode), .dacCode(dacCode));
  serial_host host (.sclk(sclk), .chipSelectN(chipSelectN), .shiftIn(shiftIn),
    .chainOut(chainOut));
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string what, input code_t seen, input code_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : waitc
  // look away from the launching edge, then hand back on a rising edge for the next drive
  task automatic cmpAll();
    @(negedge clk_sys);
    for (int i = 0; i < CHANNELS; i++)
    begin
      check($sformatf("inputCode%0d", i), inputCode[i], expIn[i]);
      check($sformatf("dacCode%0d", i), dacCode[i], expDac[i]);
    end
    @(posedge clk_sys);
  endtask : cmpAll
  // junk above the word must be dropped at chip select rise
  task automatic load(input chan_t ch, input code_t d, input int extra);
    host.send({16'hA5C3, ch, d}, 16 + extra, 1'b1);
    waitc(8);
    expIn[ch] = d;
  endtask : load
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
  initial
  begin
    arst_n = 1'b0;
    presetN = 1'b1;
    levelSelect = 1'b1;
    loadAllStrobeN = 1'b1;
    waitc(3);
    arst_n <= 1'b1;
    waitc(10);
    expIn = '{default: HALF_CODE};
    expDac = '{default: HALF_CODE};
    cmpAll();
    for (int c = 0; c < CHANNELS; c++)
      load(chan_t'(c), dat[c], 0);
    cmpAll();
    load(2'h2, 14'h0C3A, 4);
    cmpAll();
    for (int i = 16; i < 20; i++)
      check("chainOut", code_t'(host.seen[i]), code_t'(host.sent[i - 16]));
    // clocks while deselected, then a short frame keeps older upper bits
    host.send(32'h0000_FFFF, 16, 1'b0);
    host.send(32'h0000_005A, 8, 1'b1);
    waitc(8);
    expIn[0] = 14'h3A5A;
    cmpAll();
    host.hold(1'b0);
    waitc(2);
    loadAllStrobeN <= 1'b0;
    waitc(5);
    expDac = expIn;
    cmpAll();
    // a whole frame and its select rise while the strobe is low run straight through
    load(2'h0, 14'h0F0F, 0);
    expDac[0] = 14'h0F0F;
    cmpAll();
    loadAllStrobeN <= 1'b1;
    waitc(8);
    load(2'h1, 14'h2222, 0);
    cmpAll();
    for (int lv = 0; lv < 2; lv++)
    begin
      levelSelect <= lv[0];
      waitc(4);
      presetN <= 1'b0;
      waitc(5);
      expIn = '{default: (lv == 1) ? HALF_CODE : ZERO_CODE};
      expDac = expIn;
      cmpAll();
      presetN <= 1'b1;
      waitc(5);
      cmpAll();
    end
    // a second power-up, this time with the level pin low
    levelSelect <= 1'b0;
    waitc(4);
    arst_n <= 1'b0;
    waitc(3);
    arst_n <= 1'b1;
    waitc(10);
    expIn = '{default: ZERO_CODE};
    expDac = expIn;
    cmpAll();
    conclude();
  end
endmodule : quad_dac_serial_load_logic_tb
`default_nettype wire
